/* File: design/lpdac_pkg.sv */
package lpdac_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [15:0] ADDR_REF_BUF_CFG = 16'h2050;
  localparam logic [15:0] ADDR_CODE_DATA = 16'h2120;
  localparam logic [15:0] ADDR_SW_CTRL = 16'h2124;
  localparam logic [15:0] ADDR_DAC_CFG = 16'h2128;
  localparam logic [15:0] ADDR_CM_MUX = 16'h235C;
  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int CFG_WIDTH = 7;
  localparam int CFG_SRC_BIT = 6;
  localparam int CFG_MODE_BIT = 5;
  localparam int CFG_ZERO_MUX_BIT = 4;
  localparam int CFG_BIAS_MUX_BIT = 3;
  localparam int CFG_REF_BIT = 2;
  localparam int CFG_PD_BIT = 1;
  localparam int CFG_WREN_BIT = 0;
  localparam int SW_WIDTH = 6;
  localparam int SW_OVR_BIT = 5;
  localparam int SW_COUNT = 5;
  localparam int DATA_WIDTH = 18;
  localparam int CODE12_LSB = 0;
  localparam int CODE6_LSB = 12;
  // ---------------------------------------------------------------
  // Reset values and switch patterns
  // ---------------------------------------------------------------
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 7'h02;
  localparam logic [SW_WIDTH-1:0] SW_RESET = 6'h00;
  localparam logic [DATA_WIDTH-1:0] DATA_RESET = 18'h00000;
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [SW_COUNT-1:0] SW_NORMAL = 5'h0C;
  localparam logic [SW_COUNT-1:0] SW_DIAG = 5'h11;
  localparam logic [SW_COUNT-1:0] SW_ALL_OPEN = 5'h00;
  // ---------------------------------------------------------------
  // Data update latency
  // ---------------------------------------------------------------
  localparam int UPDATE_CYCLES = 10;
  localparam logic [3:0] UPDATE_LAST = 4'(UPDATE_CYCLES - 1);
endpackage

/* File: design/lpdac_regs.sv */
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
// Operation
// - Config bit 6 picks code source
// - Config bit 5 picks switch mode
// - Normal closes two,three; diagnostic zero,four
// - Override bit makes switches follow bits
// - Config bit 4 selects zero-node output
// - Config bit 3 selects bias-node output
// - Config bit 2 selects DAC reference
// - Power-down opens every switch; resets set
// - Write enable clear forces data zero
// - Config resets 0x2, upper bits reserved
// - Config and switch registers at offsets
// - Data register at offset, resets zero
// - Reference and mux registers, reset zero
// - Data holds 12-bit and 6-bit codes
// - Data update effective ten cycles later
module lpdac_regs
  import lpdac_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic code_source_select,
  output logic reference_select,
  output logic dac_power_down,
  output logic zero_node_mux_select,
  output logic bias_node_mux_select,
  output logic [SW_COUNT-1:0] output_switch,
  output logic [11:0] code12,
  output logic [5:0] code6,
  output logic [31:0] reference_buffer_config,
  output logic [31:0] common_mode_mux_select
);
  import lpdac_pkg::*;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [CFG_WIDTH-1:0] cfg_ff;
  logic [SW_WIDTH-1:0] sw_ff;
  logic [DATA_WIDTH-1:0] data_ff;
  logic [DATA_WIDTH-1:0] pend_ff;
  logic [3:0] upd_cnt_ff;
  logic upd_busy_ff;
  logic [31:0] refbuf_ff;
  logic [31:0] cmmux_ff;
  logic [SW_COUNT-1:0] nxt_switch;
  logic [31:0] nxt_rdata;
  logic acc;
  logic wr;

  // Single-cycle access phase: the slave answers at the first access edge
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  // ---------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_ff <= CFG_RESET;
    else if (wr && hit(paddr, ADDR_DAC_CFG))
      // software keeps mux bits equal; stored as written
      cfg_ff <= pwdata[CFG_WIDTH-1:0];
  end

  // ---------------------------------------------------------------
  // Switch control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sw_ff <= SW_RESET;
    else if (wr && hit(paddr, ADDR_SW_CTRL))
      sw_ff <= pwdata[SW_WIDTH-1:0];
  end

  // ---------------------------------------------------------------
  // Data register with delayed update
  // ---------------------------------------------------------------
  // The written code is staged and lands UPDATE_CYCLES edges after the write
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pend_ff <= DATA_RESET;
      upd_busy_ff <= 1'b0;
      upd_cnt_ff <= 4'h0;
    end
    else if (wr && hit(paddr, ADDR_CODE_DATA) && cfg_ff[CFG_WREN_BIT])
    begin
      pend_ff <= pwdata[DATA_WIDTH-1:0];
      upd_busy_ff <= 1'b1;
      upd_cnt_ff <= 4'h0;
    end
    else if (upd_busy_ff)
    begin
      if (upd_cnt_ff == UPDATE_LAST)
        upd_busy_ff <= 1'b0;
      upd_cnt_ff <= upd_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      data_ff <= DATA_RESET;
    else if (!cfg_ff[CFG_WREN_BIT])
      data_ff <= DATA_RESET;
    else if (upd_busy_ff && upd_cnt_ff == UPDATE_LAST)
      data_ff <= pend_ff;
  end

  // ---------------------------------------------------------------
  // Reference buffer and common-mode mux registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      refbuf_ff <= WORD_RESET;
      cmmux_ff <= WORD_RESET;
    end
    else
    begin
      if (wr && hit(paddr, ADDR_REF_BUF_CFG))
        refbuf_ff <= pwdata;
      if (wr && hit(paddr, ADDR_CM_MUX))
        cmmux_ff <= pwdata;
    end
  end

  // ---------------------------------------------------------------
  // Switch pattern
  // ---------------------------------------------------------------
  always_comb
  begin
    if (cfg_ff[CFG_PD_BIT])
      nxt_switch = SW_ALL_OPEN;
    else if (sw_ff[SW_OVR_BIT])
      nxt_switch = sw_ff[SW_COUNT-1:0];
    else if (cfg_ff[CFG_MODE_BIT])
      nxt_switch = SW_DIAG;
    else
      nxt_switch = SW_NORMAL;
  end

  // ---------------------------------------------------------------
  // Analog control outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      output_switch <= SW_ALL_OPEN;
      code_source_select <= 1'b0;
      reference_select <= 1'b0;
      dac_power_down <= 1'b1;
      zero_node_mux_select <= 1'b0;
      bias_node_mux_select <= 1'b0;
      code12 <= 12'h000;
      code6 <= 6'h00;
      reference_buffer_config <= WORD_RESET;
      common_mode_mux_select <= WORD_RESET;
    end
    else
    begin
      output_switch <= nxt_switch;
      code_source_select <= cfg_ff[CFG_SRC_BIT];
      reference_select <= cfg_ff[CFG_REF_BIT];
      dac_power_down <= cfg_ff[CFG_PD_BIT];
      zero_node_mux_select <= cfg_ff[CFG_ZERO_MUX_BIT];
      bias_node_mux_select <= cfg_ff[CFG_BIAS_MUX_BIT];
      code12 <= data_ff[CODE12_LSB +: 12];
      code6 <= data_ff[CODE6_LSB +: 6];
      reference_buffer_config <= refbuf_ff;
      common_mode_mux_select <= cmmux_ff;
    end
  end

  // ---------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_rdata = WORD_RESET;
    unique case (paddr)
      ADDR_DAC_CFG: nxt_rdata = {25'h0000000, cfg_ff};
      ADDR_SW_CTRL: nxt_rdata = {26'h0000000, sw_ff};
      ADDR_CODE_DATA: nxt_rdata = {14'h0000, data_ff};
      ADDR_REF_BUF_CFG: nxt_rdata = refbuf_ff;
      ADDR_CM_MUX: nxt_rdata = cmmux_ff;
      default: nxt_rdata = WORD_RESET;
    endcase
  end

  // Read data registered in setup so it is valid during the access phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= WORD_RESET;
    else if (psel && !penable && !pwrite)
      prdata <= nxt_rdata;
  end

  // pready high for one cycle in access phase; no wait states
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  // unmapped reads zero, writes dropped, no error signalled
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pslverr <= 1'b0;
    else
      pslverr <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_data_write;
    wr && hit(paddr, ADDR_CODE_DATA) && cfg_ff[CFG_WREN_BIT];
  endsequence

  // A saturating age counter stands in for a long repetition, which the tools would unroll
  logic wr_armed_ff;
  logic [3:0] wr_age_ff;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_armed_ff <= 1'b0;
      wr_age_ff <= 4'h0;
    end
    else if (wr && hit(paddr, ADDR_CODE_DATA) && cfg_ff[CFG_WREN_BIT])
    begin
      wr_armed_ff <= 1'b1;
      wr_age_ff <= 4'h0;
    end
    // Clearing write enable zeroes the data, so no landing is checked after it
    else if (!cfg_ff[CFG_WREN_BIT])
      wr_armed_ff <= 1'b0;
    else if (wr_armed_ff && wr_age_ff != 4'hF)
      wr_age_ff <= wr_age_ff + 4'h1;
  end

  sequence s_update_due;
    wr_armed_ff && wr_age_ff == 4'(UPDATE_CYCLES);
  endsequence

  sequence s_update_waiting;
    wr_armed_ff && wr_age_ff != 4'h0 && wr_age_ff < 4'(UPDATE_CYCLES);
  endsequence

  chk_data_latency: assert property (@(posedge clk) disable iff (!reset_n)
    s_update_due |-> data_ff == pend_ff)
    else $error("data update latency wrong");

  chk_data_not_early: assert property (@(posedge clk) disable iff (!reset_n)
    s_update_waiting |-> $stable(data_ff))
    else $error("data updated too early");

  chk_data_stage: assert property (@(posedge clk) disable iff (!reset_n)
    s_data_write |=> pend_ff == $past(pwdata[DATA_WIDTH-1:0]))
    else $error("data write not staged");

  chk_apb_ready: assert property (@(posedge clk) disable iff (!reset_n)
    psel && !penable |=> pready)
    else $error("ready missing in access phase");

  chk_data_zero: assert property (@(posedge clk) disable iff (!reset_n)
    !cfg_ff[CFG_WREN_BIT] |=> data_ff == DATA_RESET)
    else $error("data not zero while disabled");

  chk_pd_open: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_ff[CFG_PD_BIT] |=> output_switch == SW_ALL_OPEN)
    else $error("switches not open in power down");

  chk_normal_pattern: assert property (@(posedge clk) disable iff (!reset_n)
    !cfg_ff[CFG_PD_BIT] && !sw_ff[SW_OVR_BIT] && !cfg_ff[CFG_MODE_BIT]
    |=> output_switch == SW_NORMAL)
    else $error("normal switch pattern wrong");

  chk_diag_pattern: assert property (@(posedge clk) disable iff (!reset_n)
    !cfg_ff[CFG_PD_BIT] && !sw_ff[SW_OVR_BIT] && cfg_ff[CFG_MODE_BIT]
    |=> output_switch == SW_DIAG)
    else $error("diagnostic switch pattern wrong");

  chk_override_bits: assert property (@(posedge clk) disable iff (!reset_n)
    !cfg_ff[CFG_PD_BIT] && sw_ff[SW_OVR_BIT] |=> output_switch == $past(sw_ff[SW_COUNT-1:0]))
    else $error("override not followed");

  chk_cfg_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr && hit(paddr, ADDR_DAC_CFG) |=> ##1 code_source_select == $past(pwdata[CFG_SRC_BIT], 2)
    && reference_select == $past(pwdata[CFG_REF_BIT], 2))
    else $error("config write not applied");

  chk_mux_outputs: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> zero_node_mux_select == $past(cfg_ff[CFG_ZERO_MUX_BIT])
    && bias_node_mux_select == $past(cfg_ff[CFG_BIAS_MUX_BIT]))
    else $error("mux select outputs wrong");

  chk_unmapped_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr && !hit(paddr, ADDR_DAC_CFG) && !hit(paddr, ADDR_SW_CTRL)
    |=> $stable(cfg_ff) && $stable(sw_ff))
    else $error("unmapped write changed state");
endmodule

/* File: testbench/test_low_power_dac_control_regs.sv */
`timescale 1ns/10ps
module test_low_power_dac_control_regs;
  import lpdac_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, src, refs, pd, zmux, bmux;
  logic [SW_COUNT-1:0] sw;
  logic [11:0] code12;
  logic [5:0] code6;
  logic [31:0] refbuf, cmmux, q;
  int error_cnt = 0;
  int cmp_count = 0;
  typedef struct {logic [15:0] a; logic [31:0] d; logic [31:0] e;} lpdac_row_t;
  lpdac_row_t rows [5];

  always #5 clk = ~clk;

  lpdac_regs dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .code_source_select(src), .reference_select(refs),
    .dac_power_down(pd), .zero_node_mux_select(zmux), .bias_node_mux_select(bmux),
    .output_switch(sw), .code12(code12), .code6(code6),
    .reference_buffer_config(refbuf), .common_mode_mux_select(cmmux));

  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask

  // Holds the request until pready is seen at a rising edge
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      error_cnt++;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task test_done;
    $display("compares=%0d errors=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // -------------------------------------------------------------
  // Watchdog
  // -------------------------------------------------------------
  initial
  begin
    #200us;
    error_cnt++;
    test_done();
  end

  initial
  begin
    rows[0] = '{ADDR_REF_BUF_CFG, 32'hA5A5A5A5, 32'hA5A5A5A5};
    rows[1] = '{ADDR_CM_MUX, 32'h5A5A5A5A, 32'h5A5A5A5A};
    rows[2] = '{ADDR_SW_CTRL, 32'hFFFFFFFF, 32'h0000003F};
    rows[3] = '{ADDR_DAC_CFG, 32'hFFFFFFFF, 32'h0000007F};
    rows[4] = '{16'h212C, 32'hFFFFFFFF, 32'h00000000};
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    settle(1);
    cmp_bit(pd, 1'b1); // power-down reset
    cmp_word(32'(sw), 32'(SW_ALL_OPEN)); // switches open
    apb(1'b0, ADDR_DAC_CFG, 32'h0);
    cmp_word(q, 32'h00000002); // config reset
    apb(1'b0, ADDR_SW_CTRL, 32'h0);
    cmp_word(q, 32'h00000000); // switch reset
    apb(1'b0, ADDR_CODE_DATA, 32'h0);
    cmp_word(q, 32'h00000000); // data reset
    apb(1'b0, ADDR_REF_BUF_CFG, 32'h0);
    cmp_word(q, 32'h00000000); // reference reset
    apb(1'b0, ADDR_CM_MUX, 32'h0);
    cmp_word(q, 32'h00000000); // mux reset
    foreach (rows[i])
    begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      cmp_word(q, rows[i].e); // readback and reserved bits
    end
    cmp_word(refbuf, 32'hA5A5A5A5); // reference output
    cmp_word(cmmux, 32'h5A5A5A5A); // mux output
    apb(1'b1, ADDR_SW_CTRL, 32'h0);
    apb(1'b1, ADDR_DAC_CFG, 32'h0);
    settle(3);
    cmp_word(32'(sw), 32'(SW_NORMAL)); // normal pattern
    cmp_bit(pd, 1'b0); // powered on
    cmp_word(32'({src, zmux, bmux, refs}), 32'h0); // cleared
    // Both mux bits written equal
    apb(1'b1, ADDR_DAC_CFG, 32'h0000007D);
    settle(3);
    cmp_word(32'(sw), 32'(SW_DIAG)); // diagnostic pattern
    cmp_word(32'({src, zmux, bmux, refs}), 32'hF); // set
    apb(1'b1, ADDR_SW_CTRL, 32'h00000035);
    settle(3);
    cmp_word(32'(sw), 32'h15); // override
    apb(1'b1, ADDR_DAC_CFG, 32'h0000007F);
    settle(3);
    cmp_word(32'(sw), 32'(SW_ALL_OPEN)); // power-down beats override
    cmp_bit(pd, 1'b1); // power-down output
    apb(1'b1, ADDR_DAC_CFG, 32'h00000001);
    apb(1'b1, ADDR_CODE_DATA, 32'hFFF6B5A3);
    settle(10);
    cmp_word(32'(code12), 32'h0); // not yet updated
    settle(1);
    cmp_word(32'(code12), 32'h5A3); // low code
    cmp_word(32'(code6), 32'h2B); // high code
    apb(1'b0, ADDR_CODE_DATA, 32'h0);
    cmp_word(q, 32'h0002B5A3); // data readback
    apb(1'b1, ADDR_DAC_CFG, 32'h00000000);
    apb(1'b1, ADDR_CODE_DATA, 32'h00012345);
    settle(14);
    cmp_word(32'(code12), 32'h0); // data forced zero
    apb(1'b0, ADDR_CODE_DATA, 32'h0);
    cmp_word(q, 32'h00000000); // write ignored
    cmp_bit(pslverr, 1'b0); // no error
    // Mid-run reset: every field returns to its reset value
    @(posedge clk);
    reset_n <= 1'b0;
    settle(2);
    cmp_bit(pd, 1'b1); // power-down on reset
    cmp_word(32'(sw), 32'(SW_ALL_OPEN)); // switches open on reset
    cmp_word(refbuf, 32'h00000000); // reference output reset
    @(posedge clk);
    reset_n <= 1'b1;
    settle(1);
    apb(1'b0, ADDR_DAC_CFG, 32'h0);
    cmp_word(q, 32'h00000002); // config reset again
    test_done();
  end
endmodule
